//--- verilog/ltr_pkg.sv
// Shared constants and types for the line thermal replica block
package ltr_pkg;

    // ==========================================================
    // Timing
    localparam int CLK_PERIOD_PS = 5000;
    localparam int SAMPLE_PERIOD_US = 1000;
    localparam int SAMPLE_CYCLES = (SAMPLE_PERIOD_US * 1000) / CLK_PERIOD_PS;
    localparam logic [31:0] MS_PER_MIN = 32'h0000EA60;
    localparam logic [7:0] PULSE_UPDATES = 8'h64;

    // ==========================================================
    // Fixed-point scaling
    localparam int FRAC_BITS = 32;
    localparam int LEVEL_W = 48;
    localparam logic [31:0] PERCENT_TO_Q32 = 32'h028F5C29;
    localparam logic [31:0] DIV_ONE_Q32 = 32'hFFFFFFFF;
    localparam logic [LEVEL_W-1:0] LEVEL_RESET = 48'h000000000000;

    // ==========================================================
    // Modes and settings
    typedef enum logic [1:0] {
        LTR_OFF,
        LTR_PULSED,
        LTR_LOCKED
    } ltr_mode_t;

    typedef struct packed {
        ltr_mode_t mode;
        logic [7:0] alarm_temp;
        logic [7:0] trip_temp;
        logic [7:0] rated_temp;
        logic [7:0] base_temp;
        logic [7:0] unlock_temp;
        logic [7:0] ambient_temperature_setting;
        logic [7:0] startup_pct;
        logic [7:0] rated_current_pct;
        logic [9:0] time_const_min;
        logic sensor_en;
    } ltr_cfg_t;

    typedef struct packed {
        logic [15:0] l1;
        logic [15:0] l2;
        logic [15:0] l3;
    } ltr_rms_t;

    typedef struct packed {
        logic alarm;
        logic trip;
        logic restart_block;
    } ltr_status_t;

endpackage

//--- verilog/ltr_divider.sv
// Sequential restoring unsigned divider, one quotient bit per clock
`timescale 1ns/100ps
module ltr_divider (
    input wire logic core_clk_i,
    input wire logic rst_b_i,
    input wire logic start_i,
    input wire logic [31:0] dividend_i,
    input wire logic [31:0] divisor_i,
    output logic done_o,
    output logic [31:0] quotient_o
);
    // ==========================================================
    // Datapath
    logic [32:0] rem_q;
    logic [31:0] quo_q;
    logic [31:0] div_q;
    logic [5:0] cnt_q;
    logic busy_q;
    logic [32:0] trial;

    always_comb begin
        trial = {rem_q[31:0], quo_q[31]} - {1'b0, div_q};
    end

    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rem_q <= 33'h000000000;
            quo_q <= 32'h00000000;
            div_q <= 32'h00000000;
            cnt_q <= 6'h00;
            busy_q <= 1'b0;
            done_o <= 1'b0;
        end else begin
            done_o <= 1'b0;
            if (start_i) begin
                rem_q <= 33'h000000000;
                quo_q <= dividend_i;
                div_q <= divisor_i;
                cnt_q <= 6'h20;
                busy_q <= 1'b1;
            end else if (busy_q) begin
                // Zero divisor saturates the quotient to all ones
                if (!trial[32]) begin
                    rem_q <= trial;
                    quo_q <= {quo_q[30:0], 1'b1};
                end else begin
                    rem_q <= {rem_q[31:0], quo_q[31]};
                    quo_q <= {quo_q[30:0], 1'b0};
                end
                cnt_q <= cnt_q - 6'h01;
                if (cnt_q == 6'h01) begin
                    busy_q <= 1'b0;
                    done_o <= 1'b1;
                end
            end
        end
    end

    assign quotient_o = quo_q;
endmodule

//--- verilog/ltr_replica.sv
// Line thermal replica: max phase selection, thermal model, trip logic
// Operation
// (R1) Upstream gives per-phase RMS at 1 kHz
// (R2) Largest phase RMS is the heating current
// (R3) First-order exponential step toward current squared
// (R4) Level is overtemperature over reference overtemperature
// (R5) Reference rise is rated minus base temperature
// (R6) One time constant heats and cools
// (R7) Object temperature is overtemperature plus ambient
// (R8) Ambient from setting or sensor, one switch
// (R9) Power-up loads startup fraction, not zero
// (R10) Alarm, trip, restart block from thresholds
// (R11) Off mode holds all outputs inactive; the code clears only status_o, level and temperature keep updating
// (R12) Pulsed mode emits trip pulse above threshold
// (R13) Locked trip holds until below unlock
// (R14) Block input suppresses protection outputs
// (R15) Heat reset reloads the initial level
// (R16) One update per sample with decay factor
// (R17) Fixed pulse length, re-arm below trip
`timescale 1ns/100ps
module ltr_replica #(
    parameter int SAMPLE_CYCLES = ltr_pkg::SAMPLE_CYCLES
) (
    input wire logic core_clk_i,
    input wire logic rst_b_i,
    input wire ltr_pkg::ltr_cfg_t cfg_i,
    input wire ltr_pkg::ltr_rms_t rms_i,
    input wire logic [7:0] sensor_temp_i,
    input wire logic block_i,
    input wire logic heat_reset_i,
    output ltr_pkg::ltr_status_t status_o,
    output logic [47:0] thermal_level_o,
    output logic [15:0] object_temp_o,
    output logic update_o
);
    import ltr_pkg::*;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_RATIO,
        ST_ALPHA,
        ST_STEP,
        ST_CMP
    } ltr_state_t;

    // ==========================================================
    // Sample tick
    logic [31:0] tick_cnt_q;
    logic tick;

    assign tick = (tick_cnt_q == 32'(SAMPLE_CYCLES - 1));

    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            tick_cnt_q <= 32'h00000000;
        end else if (tick) begin
            tick_cnt_q <= 32'h00000000;
        end else begin
            tick_cnt_q <= tick_cnt_q + 32'h00000001;
        end
    end

    // ==========================================================
    // Sequencer and divider
    ltr_state_t state_q;
    logic div_start;
    logic div_done;
    logic [31:0] div_quo;
    logic [31:0] dividend;
    logic [31:0] divisor;
    logic [15:0] imax;
    logic [31:0] ratio_q;
    logic [31:0] alpha_q;

    // Max of three phases [R2]
    always_comb begin
        imax = rms_i.l1;
        if (rms_i.l2 > imax) begin
            imax = rms_i.l2;
        end
        if (rms_i.l3 > imax) begin
            imax = rms_i.l3;
        end
    end

    assign div_start = (state_q == ST_IDLE && tick) || (state_q == ST_RATIO && div_done);

    always_comb begin
        if (state_q == ST_IDLE) begin
            // Heating current over rated current, Q16 [R4]
            dividend = {imax, 16'h0000};
            divisor = {24'h000000, cfg_i.rated_current_pct};
        end else begin
            // Decay factor 1 ms over T, Q32 [R16] [R6]
            dividend = DIV_ONE_Q32;
            divisor = 32'(cfg_i.time_const_min * MS_PER_MIN);
        end
    end

    ltr_divider u_div (
        .core_clk_i(core_clk_i),
        .rst_b_i(rst_b_i),
        .start_i(div_start),
        .dividend_i(dividend),
        .divisor_i(divisor),
        .done_o(div_done),
        .quotient_o(div_quo)
    );

    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            state_q <= ST_IDLE;
            ratio_q <= 32'h00000000;
            alpha_q <= 32'h00000000;
        end else begin
            unique case (state_q)
                ST_IDLE: begin
                    if (tick) begin
                        state_q <= ST_RATIO;
                    end
                end
                ST_RATIO: begin
                    if (div_done) begin
                        ratio_q <= div_quo;
                        state_q <= ST_ALPHA;
                    end
                end
                ST_ALPHA: begin
                    if (div_done) begin
                        alpha_q <= div_quo;
                        state_q <= ST_STEP;
                    end
                end
                ST_STEP: state_q <= ST_CMP;
                ST_CMP: state_q <= ST_IDLE;
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    // ==========================================================
    // Thermal model
    logic [47:0] level_q;
    logic init_pend_q;
    logic heat_req_q;
    logic [63:0] ratio_sq;
    logic [47:0] target;
    logic [48:0] diff;
    logic [81:0] prod;
    logic [49:0] level_next;
    logic [47:0] level_init;

    assign ratio_sq = ratio_q * ratio_q;
    // Saturate: a far overload would wrap the level otherwise
    assign target = (|ratio_sq[63:48]) ? 48'hFFFFFFFFFFFF : ratio_sq[47:0];
    assign diff = {1'b0, target} - {1'b0, level_q};
    assign prod = $signed(diff) * $signed({1'b0, alpha_q});
    // Exponential step toward target [R3]
    assign level_next = {2'b00, level_q} + prod[81:FRAC_BITS];
    assign level_init = 48'(cfg_i.startup_pct * PERCENT_TO_Q32);

    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            heat_req_q <= 1'b0;
        end else if (heat_reset_i) begin
            heat_req_q <= 1'b1; // Set wins over the step clear [R15]
        end else if (state_q == ST_STEP) begin
            heat_req_q <= 1'b0;
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            level_q <= LEVEL_RESET;
            init_pend_q <= 1'b1;
        end else if (state_q == ST_STEP) begin
            init_pend_q <= 1'b0;
            if (init_pend_q) begin
                level_q <= level_init; // [R9]
            end else if (heat_req_q || heat_reset_i) begin
                level_q <= level_init; // [R15]
            end else if (level_next[49]) begin
                level_q <= 48'h000000000000;
            end else begin
                level_q <= level_next[47:0]; // [R16]
            end
        end
    end

    // ==========================================================
    // Temperature and thresholds
    logic [7:0] ref_rise;
    logic [7:0] ambient;
    logic [56:0] obj_temp;
    logic above_alarm;
    logic above_trip;
    logic below_unlock;
    logic active;

    // Reference rise at rated current [R5]
    assign ref_rise = (cfg_i.rated_temp > cfg_i.base_temp) ?
        (cfg_i.rated_temp - cfg_i.base_temp) : 8'h00;
    assign ambient = cfg_i.sensor_en ? sensor_temp_i : cfg_i.ambient_temperature_setting; // [R8]
    assign obj_temp = 57'(level_q * ref_rise) + {17'h00000, ambient, 32'h00000000}; // [R7]
    assign above_alarm = obj_temp > {17'h00000, cfg_i.alarm_temp, 32'h00000000};
    assign above_trip = obj_temp > {17'h00000, cfg_i.trip_temp, 32'h00000000};
    assign below_unlock = obj_temp < {17'h00000, cfg_i.unlock_temp, 32'h00000000};
    assign active = (cfg_i.mode != LTR_OFF) && !block_i; // [R11] [R14]

    // ==========================================================
    // Status outputs
    logic alarm_q;
    logic hot_q;
    logic pulse_q;
    logic armed_q;
    logic [7:0] pulse_cnt_q;

    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            alarm_q <= 1'b0;
            hot_q <= 1'b0;
        end else if (!active) begin
            alarm_q <= 1'b0; // [R11] [R14]
            hot_q <= 1'b0;
        end else if (state_q == ST_CMP) begin
            alarm_q <= above_alarm; // [R10]
            if (above_trip) begin
                hot_q <= 1'b1; // [R13]
            end else if (below_unlock) begin
                hot_q <= 1'b0; // [R13]
            end
        end
    end

    // Pulse is counted in updates, so it tracks the model time base
    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            pulse_q <= 1'b0;
            armed_q <= 1'b1;
            pulse_cnt_q <= 8'h00;
        end else if (!active || cfg_i.mode != LTR_PULSED) begin
            pulse_q <= 1'b0;
            armed_q <= 1'b1;
            pulse_cnt_q <= 8'h00;
        end else if (state_q == ST_CMP) begin
            if (armed_q && above_trip) begin
                pulse_q <= 1'b1; // [R12]
                armed_q <= 1'b0;
                pulse_cnt_q <= PULSE_UPDATES - 8'h01; // [R17]
            end else begin
                if (pulse_cnt_q != 8'h00) begin
                    pulse_cnt_q <= pulse_cnt_q - 8'h01;
                end else begin
                    pulse_q <= 1'b0; // [R17]
                end
                if (!above_trip) begin
                    armed_q <= 1'b1; // [R17]
                end
            end
        end
    end

    logic [15:0] obj_int_q;
    logic update_q;

    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            obj_int_q <= 16'h0000;
            update_q <= 1'b0;
        end else begin
            update_q <= (state_q == ST_CMP);
            if (state_q == ST_CMP) begin
                obj_int_q <= (|obj_temp[56:48]) ? 16'hFFFF : obj_temp[47:32];
            end
        end
    end

    assign status_o.alarm = alarm_q;
    assign status_o.trip = (cfg_i.mode == LTR_LOCKED) ? hot_q : pulse_q; // [R10]
    assign status_o.restart_block = hot_q;
    assign thermal_level_o = level_q;
    assign object_temp_o = obj_int_q;
    assign update_o = update_q;
endmodule

//--- bench/ltr_rms_model.sv
// Upstream per-phase RMS stage model
`timescale 1ns/100ps
module ltr_rms_model #(
    parameter int SAMPLE_CYCLES = 200
) (
    input wire logic core_clk_i,
    input wire logic rst_b_i,
    input wire ltr_pkg::ltr_rms_t req_i,
    output ltr_pkg::ltr_rms_t rms_o
);
    import ltr_pkg::*;
    int cnt_q;
    // ==========================================================
    // New values land mid-period, away from the capture tick
    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            cnt_q <= 0;
            rms_o <= '0;
        end else begin
            cnt_q <= (cnt_q == SAMPLE_CYCLES - 1) ? 0 : cnt_q + 1;
            if (cnt_q == SAMPLE_CYCLES / 2) begin
                rms_o <= req_i;
            end
        end
    end
endmodule

//--- bench/ltr_checker.sv
// Port assertions for the thermal replica
`timescale 1ns/100ps
module ltr_checker #(
    parameter int SAMPLE_CYCLES = 200
) (
    input wire logic core_clk_i,
    input wire logic rst_b_i,
    input wire ltr_pkg::ltr_cfg_t cfg_i,
    input wire logic block_i,
    input wire ltr_pkg::ltr_status_t status_o,
    input wire logic [47:0] thermal_level_o,
    input wire logic [15:0] object_temp_o,
    input wire logic update_o
);
    import ltr_pkg::*;
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!rst_b_i);
    logic act;
    logic seen_q;
    logic [31:0] gap_q;
    assign act = (cfg_i.mode != LTR_OFF) && !block_i;
    // ==========================================================
    // Cycles since last update
    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            gap_q <= 32'h0;
            seen_q <= 1'b0;
        end else if (update_o) begin
            gap_q <= 32'h0;
            seen_q <= 1'b1;
        end else begin
            gap_q <= gap_q + 32'h1;
        end
    end
    // ==========================================================
    // Assertions
    block_quiet_a: assert property (block_i |=> status_o == 3'h0)
        else $error("status active while blocked");
    off_quiet_a: assert property (cfg_i.mode == LTR_OFF |=> status_o == 3'h0)
        else $error("status active while off");
    alarm_cmp_a: assert property (update_o && act && $past(act) && $stable(cfg_i) |->
        (status_o.alarm || object_temp_o <= {8'h0, cfg_i.alarm_temp}) &&
        (!status_o.alarm || object_temp_o >= {8'h0, cfg_i.alarm_temp}))
        else $error("alarm disagrees with temperature");
    restart_set_a: assert property (update_o && act && $past(act) &&
        object_temp_o > {8'h0, cfg_i.trip_temp} |-> status_o.restart_block)
        else $error("restart block missing above trip");
    lock_set_a: assert property (update_o && act && $past(act) && cfg_i.mode == LTR_LOCKED &&
        object_temp_o > {8'h0, cfg_i.trip_temp} |-> status_o.trip)
        else $error("locked trip missing");
    lock_hold_a: assert property (cfg_i.mode == LTR_LOCKED && $stable(cfg_i) && act &&
        $past(act) && $past(status_o.trip) && object_temp_o >= {8'h0, cfg_i.unlock_temp}
        |-> status_o.trip) else $error("locked trip dropped early");
    pulse_rise_a: assert property (cfg_i.mode == LTR_PULSED && $stable(cfg_i) &&
        $rose(status_o.trip) |-> update_o && object_temp_o >= {8'h0, cfg_i.trip_temp})
        else $error("trip pulse without overtemperature");
    status_hold_a: assert property (!update_o && act && $past(act) && $stable(cfg_i)
        |-> $stable(status_o)) else $error("status moved between updates");
    update_gap_a: assert property (update_o && seen_q |-> gap_q == SAMPLE_CYCLES - 1)
        else $error("update spacing wrong");
    level_step_a: assert property ($changed(thermal_level_o) |-> ##1 update_o)
        else $error("level moved outside a step");
    cover property (update_o && status_o.trip);
    cover property (status_o.restart_block && cfg_i.mode == LTR_LOCKED);
    cover property (block_i && $past(status_o.alarm));
endmodule
bind ltr_replica ltr_checker #(.SAMPLE_CYCLES(SAMPLE_CYCLES)) u_chk (
    .core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .cfg_i(cfg_i), .block_i(block_i),
    .status_o(status_o), .thermal_level_o(thermal_level_o),
    .object_temp_o(object_temp_o), .update_o(update_o));

//--- bench/tb.sv
// Self-checking bench for the line thermal replica
`timescale 1ns/100ps
module tb;
    import ltr_pkg::*;
    localparam int SC = 200;
    logic core_clk_i = 1'b0;
    logic rst_b_i = 1'b0;
    ltr_cfg_t cfg = '{LTR_PULSED, 8'h50, 8'h64, 8'h64, 8'h01, 8'h3C, 8'h19, 8'h32, 8'h64,
        10'h001, 1'b0};
    ltr_rms_t req = '0;
    ltr_rms_t rms;
    ltr_status_t st;
    logic [7:0] sens = 8'h1E;
    logic blk = 1'b0;
    logic hr = 1'b0;
    logic [47:0] lvl;
    logic [15:0] obj;
    logic upd;
    logic load = 1'b1;
    logic [15:0] lfsr = 16'h0019;
    int err_count = 0;
    int cmp_count = 0;
    int cyc = 0;
    int np = 0;
    real h = 0.0;
    always #2.5 core_clk_i = ~core_clk_i;
    ltr_rms_model #(.SAMPLE_CYCLES(SC)) u_src (.core_clk_i(core_clk_i), .rst_b_i(rst_b_i),
        .req_i(req), .rms_o(rms));
    ltr_replica #(.SAMPLE_CYCLES(SC)) u_dut (.core_clk_i(core_clk_i), .rst_b_i(rst_b_i),
        .cfg_i(cfg), .rms_i(rms), .sensor_temp_i(sens), .block_i(blk), .heat_reset_i(hr),
        .status_o(st), .thermal_level_o(lvl), .object_temp_o(obj), .update_o(upd));
    // ==========================================================
    // Helpers
    function automatic logic [15:0] rnd(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    function automatic real nxt(input real hv, input int im);
        real t;
        t = (1.0 * im / cfg.rated_current_pct) ** 2;
        t = (t > 65535.0) ? 65535.0 : t;
        hv = hv + (t - hv) * (4294967295.0 / (cfg.time_const_min * 60000.0)) / 4294967296.0;
        return (hv < 0.0) ? 0.0 : hv;
    endfunction
    task automatic cmp_near(input logic [47:0] got, input real e, input real tol);
        cmp_count++;
        if ($isunknown(got) || real'(got) > e + tol || real'(got) < e - tol) begin
            err_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, longint'(e));
        end
    endtask
    task automatic cmp_bit(input logic got, input logic e);
        cmp_count++;
        if (got !== e) begin
            err_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, e);
        end
    endtask
    // Exactly one update, checked against the bench's own replica
    task automatic step_upd(input logic [15:0] a, input logic [15:0] b, input logic [15:0] c);
        int n;
        int m;
        real e;
        n = 0;
        req <= '{a, b, c};
        m = (a > b) ? a : b;
        m = (c > m) ? c : m;
        do @(negedge core_clk_i); while (upd !== 1'b1 && ++n < 4 * SC);
        if (n >= 4 * SC) err_count++;
        h = load ? cfg.startup_pct / 100.0 : nxt(h, m);
        load = 1'b0;
        cmp_near(lvl, h * 4294967296.0, h * 4294967.0 + 4096.0);
        e = $floor(h * (cfg.rated_temp - cfg.base_temp));
        e = e + (cfg.sensor_en ? sens : cfg.ambient_temperature_setting);
        cmp_near({32'h0, obj}, (e > 65535.0) ? 65535.0 : e, 1.0 + e / 1000.0);
        @(posedge core_clk_i);
    endtask
    task automatic heat(input int n, input logic [15:0] big);
        logic [15:0] v [3];
        for (int i = 0; i < n; i++) begin
            lfsr = rnd(lfsr);
            for (int k = 0; k < 3; k++) v[k] = (k == i % 3) ? big : {8'h0, lfsr[k*4 +: 8]};
            step_upd(v[0], v[1], v[2]);
            if (st.trip === 1'b1) np++;
        end
    endtask
    task automatic hr_upd(input logic [7:0] pct);
        cfg.startup_pct <= pct;
        hr <= 1'b1;
        load = 1'b1;
        @(posedge core_clk_i);
        hr <= 1'b0;
        step_upd(16'h0, 16'h0, 16'h0);
    endtask
    task automatic finish_test();
        $display("compares %0d, mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // Hang guard, about two and a half times the expected run
    always @(posedge core_clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 80000) begin
            err_count++;
            finish_test();
        end
    end
    // ==========================================================
    // Scenarios
    initial begin
        repeat (2) @(posedge core_clk_i);
        rst_b_i <= 1'b1;
        step_upd(16'h0, 16'h0, 16'h0);
        cfg.sensor_en <= 1'b1;
        step_upd(16'h0, 16'h0, 16'h0);
        cfg.sensor_en <= 1'b0;
        heat(20, 16'h0);
        $display("test model done");
        np = 0;
        heat(130, 16'h3E80);
        cmp_near(np, PULSE_UPDATES, 0.0);
        cmp_bit(st.alarm, 1'b1);
        hr_upd(8'h32);
        cmp_bit(st.restart_block, 1'b1);
        heat(3, 16'h3E80);
        cmp_bit(st.trip, 1'b1);
        hr_upd(8'h14);
        cmp_bit(st.restart_block, 1'b0);
        $display("test pulsed done");
        cfg.mode <= LTR_LOCKED;
        heat(2, 16'h3E80);
        cmp_bit(st.trip, 1'b1);
        hr_upd(8'h32);
        cmp_bit(st.trip, 1'b1);
        blk <= 1'b1;
        step_upd(16'h0, 16'h0, 16'h0);
        cmp_bit(|st, 1'b0);
        blk <= 1'b0;
        hr_upd(8'h14);
        cmp_bit(st.trip, 1'b0);
        heat(2, 16'h3E80);
        cfg.mode <= LTR_OFF;
        step_upd(16'h0, 16'h0, 16'h0);
        cmp_bit(|st, 1'b0);
        $display("test locked done");
        finish_test();
    end
endmodule
